// ==== testbench/tmc_timer_top_tb.sv ====
// Self-checking testbench for the timer count bytes and third timer.
// Assumes tmc_pkg, tmc_sync and tmc_timer_top are compiled first.
`include "tmc_params.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); \
   end \
end
module tmc_timer_top_tb;
   // ***********************************************
   // Stimulus signals and design instance
   // ***********************************************
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   tmc_pkg::tmc_sfr_req_t req = '0;
   logic irq_en = 1'b0;
   logic lo_sys = 1'b0;
   logic hi_sys = 1'b0;
   logic rtc = 1'b0;
   logic cap = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic [7:0] d;
   int num_errors = 0;
   int tests_run = 0;
   localparam logic [7:0] reg_addrs [0:8] = '{`TMC_ADDR_T0_LOW,
      `TMC_ADDR_T1_LOW, `TMC_ADDR_T0_HIGH, `TMC_ADDR_T1_HIGH,
      `TMC_ADDR_CTRL, `TMC_ADDR_RLD_LOW, `TMC_ADDR_RLD_HIGH,
      `TMC_ADDR_CNT_LOW, `TMC_ADDR_CNT_HIGH};

   always #4 clk_sys_in = ~clk_sys_in;

   tmc_timer_top i_tmc_timer_top (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .sfr_req_in(req),
      .t2_irq_en_in(irq_en),
      .t2_low_sysclk_in(lo_sys),
      .t2_high_sysclk_in(hi_sys),
      .rtc_clk_in(rtc),
      .capture_pin_in(cap),
      .sfr_rdata_out(rdata),
      .t2_irq_out(irq)
   );

   // ***********************************************
   // Bus tasks and helpers
   // ***********************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys_in);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = v;
      @(negedge clk_sys_in);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_sys_in);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk_sys_in);
      req.rd = 1'b0;
      @(negedge clk_sys_in);
      v = rdata;
   endtask

   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHECK(v, e)
   endtask

   task automatic wirq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 40) begin
         @(negedge clk_sys_in);
         n++;
      end
      `CHECK(irq, e)
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic s_regs();
      for (int i = 0; i < 9; i++)
         chk(reg_addrs[i], 8'h00);
      for (int i = 0; i < 4; i++)
         wr(reg_addrs[i], 8'hA0 | i[7:0]);
      for (int i = 0; i < 4; i++)
         chk(reg_addrs[i], 8'hA0 | i[7:0]);
      wr(8'h8E, 8'h5A);
      chk(8'h8E, 8'h00);
   endtask

   task automatic s_wrap16();
      irq_en = 1'b1;
      lo_sys = 1'b1;
      wr(`TMC_ADDR_RLD_LOW, 8'h10);
      wr(`TMC_ADDR_RLD_HIGH, 8'h20);
      wr(`TMC_ADDR_CNT_HIGH, 8'hFF);
      wr(`TMC_ADDR_CNT_LOW, 8'hF0);
      chk(`TMC_ADDR_CNT_LOW, 8'hF0);
      wr(`TMC_ADDR_CTRL, 8'h04);
      wirq(1'b1);
      chk(`TMC_ADDR_CTRL, 8'hC4);
      wr(`TMC_ADDR_CTRL, 8'h80);
      chk(`TMC_ADDR_CNT_HIGH, 8'h20);
      rd(`TMC_ADDR_CNT_LOW, d);
      `CHECK(d >= 8'h10 && d <= 8'h1F, 1'b1)
      repeat (20) @(negedge clk_sys_in);
      `CHECK(irq, 1'b1)
      irq_en = 1'b0;
      wirq(1'b0);
      chk(`TMC_ADDR_CTRL, 8'h80);
      irq_en = 1'b1;
      wr(`TMC_ADDR_CTRL, 8'h00);
      wirq(1'b0);
   endtask

   task automatic s_split_low();
      hi_sys = 1'b1;
      wr(`TMC_ADDR_CTRL, 8'h08);
      wr(`TMC_ADDR_CNT_HIGH, 8'h55);
      wr(`TMC_ADDR_RLD_LOW, 8'h80);
      wr(`TMC_ADDR_CNT_LOW, 8'hF0);
      repeat (40) @(negedge clk_sys_in);
      `CHECK(irq, 1'b0)
      chk(`TMC_ADDR_CTRL, 8'h48);
      chk(`TMC_ADDR_CNT_HIGH, 8'h55);
      wr(`TMC_ADDR_CTRL, 8'h28);
      wr(`TMC_ADDR_CNT_LOW, 8'hF0);
      wirq(1'b1);
      wr(`TMC_ADDR_CTRL, 8'h08);
      wirq(1'b0);
   endtask

   task automatic s_split_high();
      wr(`TMC_ADDR_RLD_HIGH, 8'h40);
      wr(`TMC_ADDR_CNT_HIGH, 8'hFE);
      wr(`TMC_ADDR_CTRL, 8'h0C);
      wirq(1'b1);
      wr(`TMC_ADDR_CTRL, 8'h88);
      rd(`TMC_ADDR_CNT_HIGH, d);
      `CHECK(d >= 8'h40 && d <= 8'h4F, 1'b1)
      wr(`TMC_ADDR_CTRL, 8'h00);
      hi_sys = 1'b0;
      wirq(1'b0);
   endtask

   task automatic s_capture();
      wr(`TMC_ADDR_CNT_LOW, 8'h3C);
      wr(`TMC_ADDR_CNT_HIGH, 8'hA5);
      wr(`TMC_ADDR_CTRL, 8'h11);
      cap = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      cap = 1'b0;
      wirq(1'b1);
      chk(`TMC_ADDR_RLD_LOW, 8'h3C);
      chk(`TMC_ADDR_RLD_HIGH, 8'hA5);
      wr(`TMC_ADDR_CTRL, 8'h00);
      wirq(1'b0);
   endtask

   task automatic s_rtc();
      lo_sys = 1'b0;
      wr(`TMC_ADDR_CTRL, 8'h03);
      wr(`TMC_ADDR_CNT_LOW, 8'h00);
      wr(`TMC_ADDR_CNT_HIGH, 8'h00);
      wr(`TMC_ADDR_CTRL, 8'h07);
      repeat (32) begin
         repeat (5) @(negedge clk_sys_in);
         rtc = ~rtc;
      end
      wr(`TMC_ADDR_CTRL, 8'h03);
      chk(`TMC_ADDR_CNT_LOW, 8'h02);
   endtask

   task automatic s_sys12();
      wr(`TMC_ADDR_CNT_LOW, 8'h00);
      wr(`TMC_ADDR_CTRL, 8'h04);
      repeat (120) @(negedge clk_sys_in);
      wr(`TMC_ADDR_CTRL, 8'h00);
      rd(`TMC_ADDR_CNT_LOW, d);
      `CHECK(d >= 8'h09 && d <= 8'h0B, 1'b1)
   endtask

   // ***********************************************
   // Main sequence and watchdog
   // ***********************************************
   initial begin
      repeat (12) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      s_regs();
      s_wrap16();
      s_split_low();
      s_split_high();
      s_capture();
      s_rtc();
      s_sys12();
      close_out();
   end

   initial begin
      repeat (6000) @(posedge clk_sys_in);
      num_errors++;
      close_out();
   end
endmodule
`default_nettype wire

// ==== verilog/tmc_params.svh ====
// Constants for the timer count bytes and third-timer control block.
// Assumes inclusion by bare name from the design files.
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// ******************************************************
// Register addresses
// ******************************************************
`define TMC_ADDR_T0_LOW 8'h8A
`define TMC_ADDR_T1_LOW 8'h8B
`define TMC_ADDR_T0_HIGH 8'h8C
`define TMC_ADDR_T1_HIGH 8'h8D
`define TMC_ADDR_CTRL 8'hC8
`define TMC_ADDR_RLD_LOW 8'hCA
`define TMC_ADDR_RLD_HIGH 8'hCB
`define TMC_ADDR_CNT_LOW 8'hCC
`define TMC_ADDR_CNT_HIGH 8'hCD

// ******************************************************
// Values and counts
// ******************************************************
`define TMC_RST_BYTE 8'h00
`define TMC_BYTE_MAX 8'hFF
`define TMC_WORD_ONE 16'h0001
`define TMC_T01_COUNT 4
`define TMC_SYS_DIV_LAST 4'hB
`define TMC_RTC_DIV_LAST 3'h7
`define TMC_XCLK_SYS_CAP_RTC 2'h0
`define TMC_XCLK_RTC 2'h3
`define TMC_SYNC_RTC 0
`define TMC_SYNC_CAP 1
`define TMC_SYNC_COUNT 2

`endif

// ==== verilog/tmc_pkg.sv ====
// Types shared by the timer block files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tmc_pkg;

   // Special function register access, one request per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmc_sfr_req_t;

   // Third timer control byte, bit 7 first
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_enable;
      logic capture_enable;
      logic split_enable;
      logic third_timer_run;
      logic [1:0] external_clock_select;
   } tmc_ctrl_t;

endpackage
`default_nettype wire

// ==== verilog/tmc_sync.sv ====
// Two-flop synchroniser with a rising-edge pulse.
// Assumes an asynchronous input and the system clock.
`timescale 1ns/1ns
`default_nettype none
module tmc_sync (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic async_in,
   output logic rise_out
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   logic rise_next;

   always_comb begin
      rise_next = sync_reg & ~last_reg;
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         rise_out <= rise_next;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/tmc_timer_top.sv ====
// Timer count bytes and third timer with control, reload and capture.
// Assumes single-cycle register requests on the system clock and
// asynchronous real-time clock and capture pins.
//
// Functional notes
// - First timer low byte, readable, writable, reset zero
// - First timer high byte at own address
// - Second timer low byte readable and writable
// - Second timer high byte readable and writable
// - High byte wrap sets high overflow flag
// - High flag requests interrupt; only firmware clears
// - Low byte wrap sets low flag always
// - Low overflow interrupts when both enables set
// - Capture copies count to reload, interrupts
// - Split bit chooses sixteen or two eight
// - Run gates timer; split: only high byte
// - Reload bytes hold reload or captured value
// - Clock select picks source; sources synchronised
`include "tmc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tmc_timer_top (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire tmc_pkg::tmc_sfr_req_t sfr_req_in,
   input wire logic t2_irq_en_in,
   input wire logic t2_low_sysclk_in,
   input wire logic t2_high_sysclk_in,
   input wire logic rtc_clk_in,
   input wire logic capture_pin_in,
   output logic [7:0] sfr_rdata_out,
   output logic t2_irq_out
);
   // ******************************************************
   // Synchronised external sources
   // ******************************************************
   logic [`TMC_SYNC_COUNT-1:0] ext_async;
   logic [`TMC_SYNC_COUNT-1:0] ext_rise;

   assign ext_async[`TMC_SYNC_RTC] = rtc_clk_in;
   assign ext_async[`TMC_SYNC_CAP] = capture_pin_in;

   genvar gi;
   generate
      for (gi = 0; gi < `TMC_SYNC_COUNT; gi = gi + 1) begin : g_sync
         tmc_sync u_sync (
            .clk_sys_in(clk_sys_in),
            .nrst_in(nrst_in),
            .async_in(ext_async[gi]),
            .rise_out(ext_rise[gi])
         );
      end
   endgenerate

   // ******************************************************
   // Prescalers
   // ******************************************************
   logic [3:0] sys_div_reg;
   logic [3:0] sys_div_next;
   logic [2:0] rtc_div_reg;
   logic [2:0] rtc_div_next;
   logic sys_tick;
   logic rtc_tick;

   always_comb begin
      sys_tick = (sys_div_reg == `TMC_SYS_DIV_LAST);
      sys_div_next = sys_tick ? 4'h0 : sys_div_reg + 4'h1;
      rtc_tick = ext_rise[`TMC_SYNC_RTC] &
                 (rtc_div_reg == `TMC_RTC_DIV_LAST);
      rtc_div_next = rtc_div_reg;
      if (ext_rise[`TMC_SYNC_RTC]) begin
         rtc_div_next = rtc_div_reg + 3'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sys_div_reg <= 4'h0;
         rtc_div_reg <= 3'h0;
      end else begin
         sys_div_reg <= sys_div_next;
         rtc_div_reg <= rtc_div_next;
      end
   end

   // ******************************************************
   // Register decode
   // ******************************************************
   tmc_pkg::tmc_ctrl_t ctrl_reg;
   tmc_pkg::tmc_ctrl_t ctrl_next;
   logic [7:0] cnt_low_reg;
   logic [7:0] cnt_low_next;
   logic [7:0] cnt_high_reg;
   logic [7:0] cnt_high_next;
   logic [7:0] rld_low_reg;
   logic [7:0] rld_low_next;
   logic [7:0] rld_high_reg;
   logic [7:0] rld_high_next;
   logic wr_ctrl;
   logic wr_cnt_low;
   logic wr_cnt_high;
   logic wr_rld_low;
   logic wr_rld_high;

   always_comb begin
      wr_ctrl = sfr_req_in.wr & (sfr_req_in.addr == `TMC_ADDR_CTRL);
      wr_cnt_low = sfr_req_in.wr &
                   (sfr_req_in.addr == `TMC_ADDR_CNT_LOW);
      wr_cnt_high = sfr_req_in.wr &
                    (sfr_req_in.addr == `TMC_ADDR_CNT_HIGH);
      wr_rld_low = sfr_req_in.wr &
                   (sfr_req_in.addr == `TMC_ADDR_RLD_LOW);
      wr_rld_high = sfr_req_in.wr &
                    (sfr_req_in.addr == `TMC_ADDR_RLD_HIGH);
   end

   // ******************************************************
   // First and second timer count bytes
   // ******************************************************
   logic [7:0] t01_reg [`TMC_T01_COUNT];
   logic [7:0] t01_next [`TMC_T01_COUNT];

   always_comb begin
      for (int i = 0; i < `TMC_T01_COUNT; i++) begin
         t01_next[i] = t01_reg[i];
         if (sfr_req_in.wr &&
             sfr_req_in.addr == `TMC_ADDR_T0_LOW + 8'(i)) begin
            t01_next[i] = sfr_req_in.wdata;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < `TMC_T01_COUNT; i++) begin
            t01_reg[i] <= `TMC_RST_BYTE;
         end
      end else begin
         t01_reg <= t01_next;
      end
   end

   // ******************************************************
   // Third timer
   // ******************************************************
   logic ext_tick;
   logic tick_low;
   logic tick_high;
   logic cap_ev;
   logic lo_wrap;
   logic hi_wrap;
   logic [15:0] cnt_inc;

   always_comb begin
      ext_tick = (ctrl_reg.external_clock_select == `TMC_XCLK_RTC) ?
                 rtc_tick : sys_tick;
      tick_low = t2_low_sysclk_in | ext_tick;
      tick_high = t2_high_sysclk_in | ext_tick;
      cap_ev = ctrl_reg.capture_enable &
               ((ctrl_reg.external_clock_select ==
                 `TMC_XCLK_SYS_CAP_RTC) ?
                rtc_tick : ext_rise[`TMC_SYNC_CAP]);
      cnt_inc = {cnt_high_reg, cnt_low_reg} + `TMC_WORD_ONE;
      cnt_low_next = cnt_low_reg;
      cnt_high_next = cnt_high_reg;
      lo_wrap = 1'b0;
      hi_wrap = 1'b0;
      if (!ctrl_reg.split_enable) begin
         if (ctrl_reg.third_timer_run && tick_low) begin
            lo_wrap = (cnt_low_reg == `TMC_BYTE_MAX);
            hi_wrap = lo_wrap & (cnt_high_reg == `TMC_BYTE_MAX);
            cnt_low_next = cnt_inc[7:0];
            cnt_high_next = cnt_inc[15:8];
            if (hi_wrap && !ctrl_reg.capture_enable) begin
               cnt_low_next = rld_low_reg;
               cnt_high_next = rld_high_reg;
            end
         end
      end else begin
         if (tick_low) begin
            lo_wrap = (cnt_low_reg == `TMC_BYTE_MAX);
            cnt_low_next = cnt_low_reg + 8'h01;
            if (lo_wrap && !ctrl_reg.capture_enable) begin
               cnt_low_next = rld_low_reg;
            end
         end
         if (ctrl_reg.third_timer_run && tick_high) begin
            hi_wrap = (cnt_high_reg == `TMC_BYTE_MAX);
            cnt_high_next = cnt_high_reg + 8'h01;
            if (hi_wrap && !ctrl_reg.capture_enable) begin
               cnt_high_next = rld_high_reg;
            end
         end
      end
      if (wr_cnt_low) begin
         cnt_low_next = sfr_req_in.wdata;
      end
      if (wr_cnt_high) begin
         cnt_high_next = sfr_req_in.wdata;
      end
   end

   always_comb begin
      rld_low_next = rld_low_reg;
      rld_high_next = rld_high_reg;
      if (wr_rld_low) begin
         rld_low_next = sfr_req_in.wdata;
      end
      if (wr_rld_high) begin
         rld_high_next = sfr_req_in.wdata;
      end
      if (cap_ev) begin
         rld_low_next = cnt_low_reg;
         rld_high_next = cnt_high_reg;
      end
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = tmc_pkg::tmc_ctrl_t'(sfr_req_in.wdata);
      end
      if (hi_wrap || cap_ev) begin
         ctrl_next.high_overflow_flag = 1'b1;
      end
      if (lo_wrap) begin
         ctrl_next.low_overflow_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_reg <= tmc_pkg::tmc_ctrl_t'(`TMC_RST_BYTE);
         cnt_low_reg <= `TMC_RST_BYTE;
         cnt_high_reg <= `TMC_RST_BYTE;
         rld_low_reg <= `TMC_RST_BYTE;
         rld_high_reg <= `TMC_RST_BYTE;
      end else begin
         ctrl_reg <= ctrl_next;
         cnt_low_reg <= cnt_low_next;
         cnt_high_reg <= cnt_high_next;
         rld_low_reg <= rld_low_next;
         rld_high_reg <= rld_high_next;
      end
   end

   // ******************************************************
   // Read data and interrupt request
   // ******************************************************
   logic [7:0] rdata_next;
   logic irq_next;

   always_comb begin
      irq_next = t2_irq_en_in & (ctrl_reg.high_overflow_flag |
                 (ctrl_reg.low_overflow_flag &
                  ctrl_reg.low_overflow_irq_enable));
      rdata_next = sfr_rdata_out;
      if (sfr_req_in.rd) begin
         case (sfr_req_in.addr)
            `TMC_ADDR_T0_LOW: rdata_next = t01_reg[0];
            `TMC_ADDR_T1_LOW: rdata_next = t01_reg[1];
            `TMC_ADDR_T0_HIGH: rdata_next = t01_reg[2];
            `TMC_ADDR_T1_HIGH: rdata_next = t01_reg[3];
            `TMC_ADDR_CTRL: rdata_next = ctrl_reg;
            `TMC_ADDR_RLD_LOW: rdata_next = rld_low_reg;
            `TMC_ADDR_RLD_HIGH: rdata_next = rld_high_reg;
            `TMC_ADDR_CNT_LOW: rdata_next = cnt_low_reg;
            `TMC_ADDR_CNT_HIGH: rdata_next = cnt_high_reg;
            default: rdata_next = `TMC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sfr_rdata_out <= `TMC_RST_BYTE;
         t2_irq_out <= 1'b0;
      end else begin
         sfr_rdata_out <= rdata_next;
         t2_irq_out <= irq_next;
      end
   end

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   t0_high_write_a: assert property (
      sfr_req_in.wr && sfr_req_in.addr == `TMC_ADDR_T0_HIGH |=>
      t01_reg[2] == $past(sfr_req_in.wdata) ##1
      (sfr_req_in.rd == 1'b0) || $stable(t01_reg[2]) ||
      $past(sfr_req_in.wr))
      else $error("first timer high byte not written");

   high_flag_set_a: assert property (
      hi_wrap |=> ctrl_reg.high_overflow_flag)
      else $error("high overflow flag not set on wrap");

   high_flag_hold_a: assert property (
      ctrl_reg.high_overflow_flag && !wr_ctrl |=>
      ctrl_reg.high_overflow_flag)
      else $error("high overflow flag cleared by hardware");

   low_flag_set_a: assert property (
      tick_low && cnt_low_reg == `TMC_BYTE_MAX && !wr_cnt_low &&
      (ctrl_reg.split_enable || ctrl_reg.third_timer_run) |=>
      ctrl_reg.low_overflow_flag)
      else $error("low overflow flag not set on low wrap");

   low_irq_a: assert property (
      t2_irq_en_in && ctrl_reg.low_overflow_flag &&
      ctrl_reg.low_overflow_irq_enable |=> t2_irq_out)
      else $error("low overflow interrupt missing");

   capture_copy_a: assert property (
      cap_ev |=> {rld_high_reg, rld_low_reg} ==
      {$past(cnt_high_reg), $past(cnt_low_reg)} &&
      ctrl_reg.high_overflow_flag)
      else $error("capture did not copy count");

   stopped_hold_a: assert property (
      !ctrl_reg.split_enable && !ctrl_reg.third_timer_run &&
      !wr_cnt_low && !wr_cnt_high |=>
      $stable(cnt_low_reg) && $stable(cnt_high_reg))
      else $error("16-bit timer moved while stopped");

   split_low_run_a: assert property (
      ctrl_reg.split_enable && !ctrl_reg.third_timer_run &&
      tick_low && !wr_cnt_low && cnt_low_reg != `TMC_BYTE_MAX |=>
      cnt_low_reg == $past(cnt_low_reg) + 8'h01)
      else $error("split low byte did not count");

   reload_cycle_a: assert property (
      hi_wrap && !ctrl_reg.split_enable &&
      !ctrl_reg.capture_enable && !wr_cnt_low && !wr_cnt_high |=>
      cnt_low_reg == $past(rld_low_reg) &&
      cnt_high_reg == $past(rld_high_reg))
      else $error("reload not applied at overflow");

   count_write_a: assert property (
      wr_cnt_low |=> cnt_low_reg == $past(sfr_req_in.wdata))
      else $error("count write not applied");
endmodule
`default_nettype wire
